// *** casm_chan_if.sv ***
`timescale 1ns/100ps
interface casm_chan_if;
	logic [7:0] mode;
	logic [15:0] count;
	logic [15:0] compare;
	logic ten_bit;
	logic pin_level;
	logic event_pulse;
	logic capture_pulse;
	logic [15:0] capture_value;
	logic pin_out;
	logic pin_oe_n;

	// the array control side feeds settings and sampled pin level
	modport ctrl (
		output mode, count, compare, ten_bit, pin_level,
		input event_pulse, capture_pulse, capture_value, pin_out, pin_oe_n
	);

	// one timer/capture module
	modport chan (
		input mode, count, compare, ten_bit, pin_level,
		output event_pulse, capture_pulse, capture_value, pin_out, pin_oe_n
	);
endinterface : casm_chan_if

// *** casm_channel.sv ***
`timescale 1ns/100ps
module casm_channel (
	input logic clk,
	input logic rst_n,
	casm_chan_if.chan link
);
	typedef struct packed {
		logic primed;
		logic pin_prev;
		logic equal_prev;
		logic toggle_level;
		logic pin_out;
		logic pin_oe_n;
		logic event_pulse;
		logic capture_pulse;
		logic [15:0] capture_value;
	} casm_chan_state_type;

	casm_chan_state_type state_q;
	casm_chan_state_type state_d;
	logic comp_en;
	logic rise_en;
	logic fall_en;
	logic match_en;
	logic toggle_en;
	logic [1:0] pwm_sel;
	logic capture_mode;
	logic equal_now;
	logic match_pulse;
	logic rise_seen;
	logic fall_seen;
	logic capture_hit;
	logic pwm_level;

	// mode field split
	assign comp_en = link.mode[casm_pkg::MODE_COMP_EN_BIT];
	assign rise_en = link.mode[casm_pkg::MODE_RISE_BIT];
	assign fall_en = link.mode[casm_pkg::MODE_FALL_BIT];
	assign match_en = link.mode[casm_pkg::MODE_MATCH_BIT];
	assign toggle_en = link.mode[casm_pkg::MODE_TOGGLE_BIT];
	assign pwm_sel = link.mode[casm_pkg::MODE_PWM_HI_BIT:
		casm_pkg::MODE_PWM_LO_BIT];

	// capture ignores irq and comparator enables
	assign capture_mode = (rise_en | fall_en) &
		((link.mode & casm_pkg::MODE_OUTPUT_MASK) == '0);

	// comparator: one pulse per arrival at the compare value
	assign equal_now = comp_en & (link.count == link.compare);
	assign match_pulse = equal_now & ~state_q.equal_prev;

	// edge detection on the synchronised pin, quiet until primed
	assign rise_seen = state_q.primed & link.pin_level & ~state_q.pin_prev;
	assign fall_seen = state_q.primed & ~link.pin_level & state_q.pin_prev;
	assign capture_hit = capture_mode &
		((rise_seen & rise_en) | (fall_seen & fall_en));

	// pwm waveform, high while the count is below the compare value
	always_comb begin
		pwm_level = 1'b0;
		case (pwm_sel)
			casm_pkg::PWM_FIXED8: begin
				pwm_level = link.count[casm_pkg::PWM_NARROW_BITS-1:0] <
					link.compare[casm_pkg::PWM_NARROW_BITS-1:0];
			end
			casm_pkg::PWM_PROG8: begin
				pwm_level = link.count[casm_pkg::PWM_NARROW_BITS-1:0] <
					link.compare[casm_pkg::PWM_NARROW_BITS-1:0];
			end
			casm_pkg::PWM_WIDE: begin
				if (link.ten_bit) begin
					pwm_level = link.count[casm_pkg::PWM_TEN_BITS-1:0] <
						link.compare[casm_pkg::PWM_TEN_BITS-1:0];
				end else begin
					pwm_level = link.count < link.compare;
				end
			end
			default: begin
				pwm_level = 1'b0;
			end
		endcase
	end

	// next state of the module
	always_comb begin
		state_d = state_q;
		state_d.primed = 1'b1;
		state_d.pin_prev = link.pin_level;
		state_d.equal_prev = equal_now;
		if (comp_en && toggle_en && match_pulse) begin
			state_d.toggle_level = ~state_q.toggle_level;
		end
		state_d.event_pulse = capture_hit |
			(match_pulse & match_en & (pwm_sel == casm_pkg::PWM_OFF));
		state_d.capture_pulse = capture_hit;
		if (capture_hit) begin
			state_d.capture_value = link.count;
		end
		if (pwm_sel != casm_pkg::PWM_OFF) begin
			state_d.pin_oe_n = 1'b0;
			state_d.pin_out = pwm_level & comp_en;
		end else if (comp_en && toggle_en) begin
			state_d.pin_oe_n = 1'b0;
			state_d.pin_out = state_d.toggle_level;
		end else begin
			state_d.pin_oe_n = 1'b1;
			state_d.pin_out = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= '{pin_oe_n: 1'b1, default: '0};
		end else begin
			state_q <= state_d;
		end
	end

	assign link.event_pulse = state_q.event_pulse;
	assign link.capture_pulse = state_q.capture_pulse;
	assign link.capture_value = state_q.capture_value;
	assign link.pin_out = state_q.pin_out;
	assign link.pin_oe_n = state_q.pin_oe_n;
endmodule : casm_channel

// *** casm_pkg.sv ***
package casm_pkg;

	// array dimensions
	localparam int unsigned NUM_MODULES = 6;
	localparam int unsigned GROUP0_MODULES = 3;
	localparam int unsigned COUNT_BITS = 16;
	localparam int unsigned PWM_NARROW_BITS = 8;
	localparam int unsigned PWM_TEN_BITS = 10;

	// special function register addresses
	localparam logic [7:0] STATUS_ADDR = 8'hA5;
	localparam logic [7:0] MODE_BASE_ADDR = 8'hD9;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// status register layout
	localparam int unsigned COUNTER1_ROLLOVER_FLAG_BIT = 7;
	localparam int unsigned COUNTER0_ROLLOVER_FLAG_BIT = 3;
	localparam int unsigned EVT_POS [NUM_MODULES] = '{0, 1, 2, 4, 5, 6};

	// mode register layout
	localparam int unsigned MODE_IRQ_EN_BIT = 7;
	localparam int unsigned MODE_COMP_EN_BIT = 6;
	localparam int unsigned MODE_RISE_BIT = 5;
	localparam int unsigned MODE_FALL_BIT = 4;
	localparam int unsigned MODE_MATCH_BIT = 3;
	localparam int unsigned MODE_TOGGLE_BIT = 2;
	localparam int unsigned MODE_PWM_HI_BIT = 1;
	localparam int unsigned MODE_PWM_LO_BIT = 0;
	localparam logic [7:0] MODE_OUTPUT_MASK = 8'h0F;

	// pwm field codes
	localparam logic [1:0] PWM_OFF = 2'h0;
	localparam logic [1:0] PWM_FIXED8 = 2'h1;
	localparam logic [1:0] PWM_PROG8 = 2'h2;
	localparam logic [1:0] PWM_WIDE = 2'h3;

	// decoded module function, as seen by software
	typedef enum logic [3:0] {
		FUNC_IDLE = 4'h0,
		FUNC_PWM8_FIXED = 4'h1,
		FUNC_PWM8_PROG = 4'h2,
		FUNC_PWM_WIDE = 4'h3,
		FUNC_TOGGLE = 4'h4,
		FUNC_SW_TIMER = 4'h5,
		FUNC_CAP_FALL = 4'h6,
		FUNC_CAP_RISE = 4'h7,
		FUNC_CAP_BOTH = 4'h8,
		FUNC_UNDEFINED = 4'hF
	} casm_func_type;

endpackage : casm_pkg

// *** casm_props.sv ***
`timescale 1ns/100ps
module casm_props (
	input logic clk,
	input logic rst_n,
	input logic [7:0] sfr_addr,
	input logic sfr_wr,
	input logic sfr_rd,
	input logic [7:0] sfr_wdata,
	input logic [7:0] sfr_rdata,
	input logic counter0_rollover,
	input logic counter1_rollover,
	input logic counter0_rollover_irq_enable,
	input logic counter1_rollover_irq_enable,
	input logic [5:0] module_pin_in,
	input logic [5:0] module_pin_oe_n,
	input logic [5:0] capture_strobe,
	input casm_pkg::casm_func_type [5:0] module_function,
	input logic array_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic st_wr;
	logic m0_wr;
	logic [7:0] wd_q;
	// decoded writes to status and to module 0 mode
	assign st_wr = sfr_wr && sfr_addr == 8'hA5;
	assign m0_wr = sfr_wr && sfr_addr == 8'hD9;
	// write data bus one cycle late, sampled every clock, for decode checks
	always_ff @(posedge clk) begin
		wd_q <= sfr_wdata;
	end
	AST_COUNTER1_ROLLOVER_FLAG_IRQ: assert property (counter1_rollover &&
		counter1_rollover_irq_enable ##1 counter1_rollover_irq_enable
		|-> array_irq) else $error("counter1_rollover_flag irq missing");
	AST_COUNTER0_ROLLOVER_FLAG_IRQ: assert property (counter0_rollover &&
		counter0_rollover_irq_enable ##1 counter0_rollover_irq_enable
		|-> array_irq) else $error("counter0_rollover_flag irq missing");
	AST_HOLD: assert property (!sfr_wr && array_irq ##1
		$stable(counter0_rollover_irq_enable) &&
		$stable(counter1_rollover_irq_enable) |-> array_irq)
		else $error("irq dropped without write");
	AST_SW_SET: assert property (st_wr ##1 !sfr_wr ##1
		(sfr_rd && sfr_addr == 8'hA5) |=>
		(sfr_rdata & $past(sfr_wdata, 3)) == $past(sfr_wdata, 3))
		else $error("status write lost");
	AST_RESET_IDLE: assert property ($rose(rst_n) |-> !array_irq &&
		&module_pin_oe_n && module_function == '0)
		else $error("not idle after reset");
	// decode follows the mode at once, pin enable one register later
	AST_PWM_FUNC: assert property (m0_wr && sfr_wdata[7:2] == 6'h10 &&
		sfr_wdata[1:0] != 2'h0 |=>
		module_function[0] == {2'h0, wd_q[1:0]} ##1 !module_pin_oe_n[0])
		else $error("pwm decode wrong");
	AST_CAP_FUNC: assert property (m0_wr && sfr_wdata[3:0] == 4'h0 &&
		sfr_wdata[5:4] != 2'h0 |=>
		module_function[0] == {2'h0, wd_q[5:4]} + 4'h5)
		else $error("capture decode wrong");
	AST_CAP_SRC: assert property (capture_strobe[0] |->
		$past(module_pin_in[0], 2) != $past(module_pin_in[0], 3) ||
		$past(module_pin_in[0], 3) != $past(module_pin_in[0], 4))
		else $error("capture without pin edge");
	AST_TOGGLE_OE: assert property (m0_wr && sfr_wdata == 8'h4C
		|=> ##1 !module_pin_oe_n[0]) else $error("toggle pin not driven");
	// main scenarios reached
	cover property (capture_strobe[0]);
	cover property (array_irq);
	cover property (!module_pin_oe_n[0]);
endmodule : casm_props
bind casm_top casm_props casm_props_i (.clk, .rst_n, .sfr_addr, .sfr_wr,
	.sfr_rd, .sfr_wdata, .sfr_rdata, .counter0_rollover, .counter1_rollover,
	.counter0_rollover_irq_enable, .counter1_rollover_irq_enable,
	.module_pin_in, .module_pin_oe_n, .capture_strobe, .module_function,
	.array_irq);

// *** casm_sync.sv ***
`timescale 1ns/100ps
module casm_sync #(
	parameter int unsigned WIDTH = 6
) (
	input logic clk,
	input logic rst_n,
	input logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} casm_sync_state_type;

	casm_sync_state_type state_q;
	casm_sync_state_type state_d;

	// two flops; only the second stage is visible
	always_comb begin
		state_d.meta = async_in;
		state_d.stable = state_q.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign sync_out = state_q.stable;
endmodule : casm_sync

// *** casm_top.sv ***
// Notes on behaviour
// - rollover sets status bit seven or three
// - overflow interrupts only with rollover enable
// - software sets or clears overflow; hardware never clears
// - match or capture sets module event flag
// - event flags hold until software clears them
// - eight sources ORed into one interrupt
// - event flag interrupts only with mode bit seven
// - bit six enables the comparator
// - bit five captures count on rising pin
// - bit four captures count on falling pin
// - both bits capture on every pin transition
// - capture ignores irq and comparator enables
// - toggle bit inverts pin on each match
// - pwm code one: fixed 8-bit pwm
// - pwm code two: programmable 8-bit pwm
// - pwm code three: 10 or 16-bit pwm
// - nonzero pwm field drives the pin
// - ten-bit select: zero 16-bit, one 10-bit
// - all-zero mode means idle; all reset zero
`timescale 1ns/100ps
module casm_top #(
	parameter logic [7:0] MODE_BASE = casm_pkg::MODE_BASE_ADDR
) (
	input logic clk,
	input logic rst_n,
	input logic [7:0] sfr_addr,
	input logic sfr_wr,
	input logic sfr_rd,
	input logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input logic [15:0] counter0_value,
	input logic [15:0] counter1_value,
	input logic counter0_rollover,
	input logic counter1_rollover,
	input logic counter0_rollover_irq_enable,
	input logic counter1_rollover_irq_enable,
	input logic counter0_ten_bit_pwm_select,
	input logic counter1_ten_bit_pwm_select,
	input logic [5:0][15:0] module_compare,
	input logic [5:0] module_pin_in,
	output logic [5:0] module_pin_out,
	output logic [5:0] module_pin_oe_n,
	output logic [5:0][15:0] capture_value,
	output logic [5:0] capture_strobe,
	output casm_pkg::casm_func_type [5:0] module_function,
	output logic array_irq
);
	localparam int unsigned N = casm_pkg::NUM_MODULES;

	typedef struct packed {
		logic [7:0] flags;
		logic [5:0][7:0] mode;
		logic [7:0] rdata;
	} casm_top_state_type;

	casm_top_state_type state_q;
	casm_top_state_type state_d;
	logic [N-1:0] pin_level;
	logic [N-1:0] evt_set;
	logic [N-1:0] evt_irq_term;
	logic [7:0] flag_set;
	logic [7:0] status_base;
	logic [7:0] mode_offset;
	logic status_hit;
	logic mode_hit;
	logic [7:0] read_value;
	logic ovf_irq_term;

	// decode one mode register into the function it selects
	function automatic casm_pkg::casm_func_type casm_decode(
		input logic [7:0] mode
	);
		logic comp;
		logic rise;
		logic fall;
		logic match;
		logic tog;
		logic [1:0] pwm;
		comp = mode[casm_pkg::MODE_COMP_EN_BIT];
		rise = mode[casm_pkg::MODE_RISE_BIT];
		fall = mode[casm_pkg::MODE_FALL_BIT];
		match = mode[casm_pkg::MODE_MATCH_BIT];
		tog = mode[casm_pkg::MODE_TOGGLE_BIT];
		pwm = mode[casm_pkg::MODE_PWM_HI_BIT:casm_pkg::MODE_PWM_LO_BIT];
		casm_decode = casm_pkg::FUNC_UNDEFINED;
		if (mode == casm_pkg::MODE_RESET) begin
			casm_decode = casm_pkg::FUNC_IDLE;
		end else if (rise | fall) begin
			if ((mode & casm_pkg::MODE_OUTPUT_MASK) == '0) begin
				if (rise && fall) begin
					casm_decode = casm_pkg::FUNC_CAP_BOTH;
				end else if (rise) begin
					casm_decode = casm_pkg::FUNC_CAP_RISE;
				end else begin
					casm_decode = casm_pkg::FUNC_CAP_FALL;
				end
			end
		end else if (comp && pwm != casm_pkg::PWM_OFF) begin
			if (!match && !tog) begin
				case (pwm)
					casm_pkg::PWM_FIXED8: begin
						casm_decode = casm_pkg::FUNC_PWM8_FIXED;
					end
					casm_pkg::PWM_PROG8: begin
						casm_decode = casm_pkg::FUNC_PWM8_PROG;
					end
					default: begin
						casm_decode = casm_pkg::FUNC_PWM_WIDE;
					end
				endcase
			end
		end else if (comp && match) begin
			if (tog) begin
				casm_decode = casm_pkg::FUNC_TOGGLE;
			end else begin
				casm_decode = casm_pkg::FUNC_SW_TIMER;
			end
		end
	endfunction : casm_decode

	// module pins come from outside the clock domain
	casm_sync #(
		.WIDTH(N)
	) casm_sync_i (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(module_pin_in),
		.sync_out(pin_level)
	);

	// one timer/capture module per channel
	generate
		for (genvar g = 0; g < N; g++) begin : g_module
			casm_chan_if link ();

			assign link.mode = state_q.mode[g];
			assign link.pin_level = pin_level[g];
			assign link.compare = module_compare[g];
			// first group runs on counter 0, second on counter 1
			if (g < casm_pkg::GROUP0_MODULES) begin : g_grp0
				assign link.count = counter0_value;
				assign link.ten_bit = counter0_ten_bit_pwm_select;
			end else begin : g_grp1
				assign link.count = counter1_value;
				assign link.ten_bit = counter1_ten_bit_pwm_select;
			end

			casm_channel casm_channel_i (
				.clk(clk),
				.rst_n(rst_n),
				.link(link)
			);

			assign evt_set[g] = link.event_pulse;
			assign capture_strobe[g] = link.capture_pulse;
			assign capture_value[g] = link.capture_value;
			assign module_pin_out[g] = link.pin_out;
			assign module_pin_oe_n[g] = link.pin_oe_n;
			assign module_function[g] = casm_decode(state_q.mode[g]);

			// event flag gated by the module irq enable
			assign evt_irq_term[g] =
				state_q.flags[casm_pkg::EVT_POS[g]] &
				state_q.mode[g][casm_pkg::MODE_IRQ_EN_BIT];
		end
	endgenerate

	// register address decode
	assign status_hit = sfr_addr == casm_pkg::STATUS_ADDR;
	assign mode_offset = sfr_addr - MODE_BASE;
	assign mode_hit = mode_offset < 8'(N);

	// read multiplexer, unmapped addresses read zero
	always_comb begin
		read_value = casm_pkg::UNMAPPED_READ;
		if (status_hit) begin
			read_value = state_q.flags;
		end else if (mode_hit) begin
			read_value = state_q.mode[mode_offset[2:0]];
		end
	end

	// hardware set sources for the status register
	always_comb begin
		flag_set = '0;
		flag_set[casm_pkg::COUNTER1_ROLLOVER_FLAG_BIT] = counter1_rollover;
		flag_set[casm_pkg::COUNTER0_ROLLOVER_FLAG_BIT] = counter0_rollover;
		for (int i = 0; i < N; i++) begin
			flag_set[casm_pkg::EVT_POS[i]] = evt_set[i];
		end
	end

	// register file next state; a hardware set wins over a clear
	always_comb begin
		state_d = state_q;
		status_base = state_q.flags;
		if (sfr_wr && status_hit) begin
			status_base = sfr_wdata;
		end
		state_d.flags = status_base | flag_set;
		for (int i = 0; i < N; i++) begin
			if (sfr_wr && mode_hit && mode_offset == 8'(i)) begin
				state_d.mode[i] = sfr_wdata;
			end
		end
		if (sfr_rd) begin
			state_d.rdata = read_value;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q.flags <= casm_pkg::STATUS_RESET;
			state_q.mode <= {N{casm_pkg::MODE_RESET}};
			state_q.rdata <= casm_pkg::UNMAPPED_READ;
		end else begin
			state_q <= state_d;
		end
	end

	// overflow flags gated by each counter's rollover enable
	assign ovf_irq_term =
		(state_q.flags[casm_pkg::COUNTER1_ROLLOVER_FLAG_BIT] &
		counter1_rollover_irq_enable) |
		(state_q.flags[casm_pkg::COUNTER0_ROLLOVER_FLAG_BIT] &
		counter0_rollover_irq_enable);

	// one combined interrupt for all eight sources
	assign array_irq = ovf_irq_term | (|evt_irq_term);

	assign sfr_rdata = state_q.rdata;
endmodule : casm_top

// *** casm_top_tb.sv ***
`timescale 1ns/100ps
module casm_top_tb;
	logic clk = 0;
	logic rst_n = 0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 0;
	logic sfr_rd = 0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic [15:0] counter0_value = 16'h0000;
	logic [15:0] counter1_value = 16'h0000;
	logic counter0_rollover = 0;
	logic counter1_rollover = 0;
	logic counter0_rollover_irq_enable = 0;
	logic counter1_rollover_irq_enable = 0;
	logic counter0_ten_bit_pwm_select = 0;
	logic counter1_ten_bit_pwm_select = 0;
	logic [5:0][15:0] module_compare = '0;
	logic [5:0] module_pin_in = '0;
	logic [5:0] module_pin_out;
	logic [5:0] module_pin_oe_n;
	logic [5:0][15:0] capture_value;
	logic [5:0] capture_strobe;
	casm_pkg::casm_func_type [5:0] module_function;
	logic array_irq;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	casm_top casm_top_i (.clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd,
		.sfr_wdata, .sfr_rdata, .counter0_value, .counter1_value,
		.counter0_rollover, .counter1_rollover, .counter0_rollover_irq_enable,
		.counter1_rollover_irq_enable, .counter0_ten_bit_pwm_select,
		.counter1_ten_bit_pwm_select, .module_compare, .module_pin_in,
		.module_pin_out, .module_pin_oe_n, .capture_value, .capture_strobe,
		.module_function, .array_irq);
	// clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			bad_count++;
			test_done();
		end
	end
	task test_done;
		if (bad_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1;
		@(posedge clk);
		sfr_wr <= 0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1;
		@(posedge clk);
		sfr_rd <= 0;
		#1;
		chk("rdata", 16'(e), 16'(sfr_rdata));
	endtask : rd
	task roll(input logic [1:0] b);
		@(posedge clk);
		{counter0_rollover, counter1_rollover} <= b;
		@(posedge clk);
		{counter0_rollover, counter1_rollover} <= 2'h0;
	endtask : roll
	// reset values and an unmapped read
	task t_reset;
		rd(8'hA5, 8'h00);
		for (int i = 0; i < 6; i++) rd(8'hD9 + 8'(i), 8'h00);
		rd(8'h00, 8'h00);
		chk("oe_n", 16'h003F, 16'(module_pin_oe_n));
		chk("irq", 16'h0000, 16'(array_irq));
	endtask : t_reset
	// rollover flags, their enables and software access
	task t_ovf;
		roll(2'h1);
		tick(1);
		chk("irq", 16'h0000, 16'(array_irq));
		rd(8'hA5, 8'h80);
		@(posedge clk);
		counter1_rollover_irq_enable <= 1;
		tick(1);
		chk("irq", 16'h0001, 16'(array_irq));
		wr(8'hA5, 8'h08);
		rd(8'hA5, 8'h08);
		chk("irq", 16'h0000, 16'(array_irq));
		wr(8'hA5, 8'h00);
		rd(8'hA5, 8'h00);
		@(posedge clk);
		counter0_rollover_irq_enable <= 1;
		roll(2'h3);
		tick(1);
		chk("irq", 16'h0001, 16'(array_irq));
		rd(8'hA5, 8'h88);
		wr(8'hA5, 8'h00);
		counter0_rollover_irq_enable <= 0;
		counter1_rollover_irq_enable <= 0;
	endtask : t_ovf
	// capture on module 0: hit[1] rising, hit[0] falling
	task t_cap(input logic [7:0] m, input logic [1:0] hit);
		wr(8'hD9, m);
		counter0_value <= 16'h1234;
		module_pin_in[0] <= 1;
		tick(6);
		rd(8'hA5, {7'h00, hit[1]});
		chk("irq", 16'(hit[1] & m[7]), 16'(array_irq));
		if (hit[1]) chk("cap", 16'h1234, capture_value[0]);
		wr(8'hA5, 8'h00);
		counter0_value <= 16'h5678;
		module_pin_in[0] <= 0;
		tick(6);
		rd(8'hA5, {7'h00, hit[0]});
		if (hit[0]) chk("cap", 16'h5678, capture_value[0]);
		wr(8'hA5, 8'h00);
		wr(8'hD9, 8'h00);
	endtask : t_cap
	// rising capture on module 3, which runs on counter 1
	task t_grp1;
		wr(8'hDC, 8'hA0);
		counter1_value <= 16'hBEEF;
		module_pin_in[3] <= 1;
		tick(6);
		rd(8'hA5, 8'h10);
		chk("irq", 16'h0001, 16'(array_irq));
		chk("cap", 16'hBEEF, capture_value[3]);
		wr(8'hA5, 8'h00);
		wr(8'hDC, 8'h00);
		module_pin_in[3] <= 0;
	endtask : t_grp1
	// compare match, timer flag and toggle on module 0
	task t_cmp(input logic [7:0] m, input logic f, input logic t);
		wr(8'hD9, m);
		module_compare[0] <= 16'h0005;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			counter0_value <= 16'(i);
		end
		tick(4);
		rd(8'hA5, {7'h00, f});
		chk("pin", 16'(t), 16'(module_pin_out[0]));
		chk("oe_n", 16'(!t), 16'(module_pin_oe_n[0]));
		tick(20);
		rd(8'hA5, {7'h00, f});
		wr(8'hA5, 8'h00);
	endtask : t_cmp
	// pwm codes, widths and pin drive on module 0
	task t_pwm(input logic [7:0] m, input logic ten, input logic [15:0] c,
		input logic o);
		wr(8'hD9, m);
		module_compare[0] <= 16'h0080;
		counter0_ten_bit_pwm_select <= ten;
		counter0_value <= c;
		tick(3);
		chk("func", 16'(m[1:0]), 16'(module_function[0]));
		chk("oe_n", 16'h0000, 16'(module_pin_oe_n[0]));
		chk("pwm", 16'(o), 16'(module_pin_out[0]));
	endtask : t_pwm
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1;
		t_reset();
		t_ovf();
		t_cap(8'hA0, 2'h2);
		t_cap(8'h10, 2'h1);
		t_cap(8'h70, 2'h3);
		t_cap(8'h38, 2'h0);
		t_grp1();
		t_cmp(8'h48, 1'b1, 1'b0);
		t_cmp(8'h08, 1'b0, 1'b0);
		t_cmp(8'h4C, 1'b1, 1'b1);
		t_pwm(8'h41, 1'b0, 16'h1010, 1'b1);
		t_pwm(8'h42, 1'b0, 16'h0090, 1'b0);
		t_pwm(8'h43, 1'b0, 16'h1010, 1'b0);
		t_pwm(8'h43, 1'b1, 16'h1010, 1'b1);
		test_done();
	end
endmodule : casm_top_tb
